// ### shared/asf_pkg.sv
/*
  shared constants and carrier types of the ascii serial port framer.
  assumes a single 50 MHz core clock; all times derive from its period.
*/
package asf_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int DEF_BAUD = 9600;
  localparam int TERM_N = 12;
  localparam int FIFO_DEPTH = 32;
  localparam int FT_TERM = 0;
  localparam int FT_MSG = 1;
  localparam int FT_GAP = 2;
  localparam int FT_LEN = 3;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;

  typedef enum logic [2:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE} asf_par_t;
  typedef enum logic [1:0] {HS_NONE, HS_RTSCTS, HS_DTRDSR, HS_XONXOFF} asf_hs_t;
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01, TX_PRE = 6'h02, TX_RTSON = 6'h04,
    TX_SEND = 6'h08, TX_DRAIN = 6'h10, TX_RTSOFF = 6'h20
  } asf_tx_st_t;

  typedef struct packed {
    logic en;
    logic [3:0] frame;
    logic [15:0] baud;
    asf_par_t parity;
    logic [3:0] data_bits;
    logic [1:0] stop_bits;
    logic [15:0] rts_on;
    logic [15:0] rts_off;
    asf_hs_t hs;
    logic [3:0] term_char_count;
    logic [TERM_N-1:0][7:0] term_chars;
    logic [12:0] pkt_len;
    logic [15:0] rx_msg_to;
    logic [15:0] rx_gap;
    logic rx_swap;
    logic [15:0] tx_to;
    logic [15:0] tx_min;
    logic tx_swap;
  } asf_cfg_t;

  typedef struct packed {
    logic last;
    logic [15:0] data;
  } asf_txw_t;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] nbytes;
    logic eom;
  } asf_rxw_t;
endpackage

// ### logic/asf_fifo.sv
/*
  synchronous valid/ready fifo in flip-flops, parameter width and depth.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module asf_fifo #(
  parameter int W = 17,
  parameter int D = 32
) (
  input wire logic core_clk, // clock
  input wire logic rst, // sync reset
  input wire logic [W-1:0] in_data, // write word
  input wire logic in_valid, // write request
  output logic in_ready, // room left
  output logic [W-1:0] out_data, // head word
  output logic out_valid, // head valid
  input wire logic out_ready // head taken
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } asf_fifo_st_t;
  asf_fifo_st_t s_q, s_d;
  logic push, pop;

  assign in_ready = s_q.cnt != (AW+1)'(D);
  assign out_valid = s_q.cnt != '0;
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == AW'(D-1)) ? '0 : s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(D-1)) ? '0 : s_q.rp + AW'(1);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ### logic/asf_port.sv
/*
  one ascii serial port: configuration copy, character transmitter with pre-send,
  rts on/off and timeout handling, receiver with message framing and byte pairing.
  assumes line pins synchronous to core_clk and a host that writes 16-bit words.
*/
`timescale 1ns/100ps
module asf_port import asf_pkg::*; #(
  parameter int MS_DIV = MS_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk, // 50 MHz clock
  input wire logic rst, // sync reset, high
  input wire asf_cfg_t cfg_in, // configuration image
  input wire logic cfg_load, // pulse: configuration arrives
  output asf_cfg_t cfg_rb, // readable configuration copy
  input wire asf_txw_t tx_data, // host word to send
  input wire logic tx_valid, // host word valid
  output logic tx_ready, // fifo has room
  output asf_rxw_t rx_data, // received word
  output logic rx_valid, // received word valid
  input wire logic rx_ready, // host takes word
  output logic tx_abort, // pulse: transmit timeout
  output logic rx_overrun, // pulse: word lost
  output logic rx_perr, // pulse: parity error
  output logic rx_ferr, // pulse: stop bit error
  output logic txd, // serial out
  output logic rts, // request to send
  output logic dtr, // terminal ready
  input wire logic rxd, // serial in
  input wire logic cts, // clear to send
  input wire logic dsr // set ready
);
  typedef struct packed {
    asf_cfg_t cfg;
    logic cfg_seen;
    logic [15:0] pre;
    logic tick;
    asf_tx_st_t tx_st;
    logic [15:0] tx_ms;
    logic [15:0] tx_to_ms;
    logic [18:0] tx_baud;
    logic [11:0] tx_sh;
    logic [3:0] tx_bits;
    logic tx_hi;
    logic tx_end;
    asf_txw_t tx_w;
    logic txd;
    logic rts;
    logic xoff;
    logic abort;
    logic rxd_prev;
    logic rx_busy;
    logic [18:0] rx_baud;
    logic [3:0] rx_idx;
    logic [11:0] rx_sh;
    logic [7:0] lo;
    logic have_lo;
    logic msg_act;
    logic [15:0] msg_ms;
    logic [15:0] gap_ms;
    logic [12:0] cnt;
    logic out_v;
    asf_rxw_t out;
    logic ovr;
    logic perr;
    logic ferr;
  } asf_st_t;

  asf_st_t s_q, s_d;
  asf_txw_t f_data;
  logic f_v, f_pop, run, gate, hit, end_m, ch_v, em_v;
  logic [7:0] ch, b;
  logic [11:0] exp_f;
  logic [18:0] div;
  asf_rxw_t em;

  asf_fifo #(.W($bits(asf_txw_t)), .D(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(f_data),
    .out_valid(f_v),
    .out_ready(f_pop)
  );

  // unknown codes fall back to the default rate rather than stalling the line
  function automatic logic [18:0] baud_div(input logic [15:0] c);
    int r;
    case (c)
      16'd384, 16'd3840: r = 38400;
      16'd576, 16'd5760: r = 57600;
      16'd115, 16'd1150: r = 115200;
      16'd110, 16'd150, 16'd300, 16'd600, 16'd1200, 16'd2400, 16'd4800, 16'd9600, 16'd19200: r = int'(c);
      default: r = DEF_BAUD;
    endcase
    return 19'(CLK_HZ / r);
  endfunction

  // start bit in bit 0, then data, parity and ones for the stop bits
  function automatic logic [11:0] char_frame(input logic [7:0] d, input asf_cfg_t c);
    logic [11:0] f;
    logic p;
    f = '1;
    f[0] = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (k < c.data_bits) f[k+1] = d[k];
    end
    p = ^(d & (8'hff >> (8 - c.data_bits)));
    case (c.parity)
      PAR_ODD: p = ~p;
      PAR_MARK: p = 1'b1;
      PAR_SPACE: p = 1'b0;
      default: p = p;
    endcase
    if (c.parity != PAR_NONE) f[c.data_bits+1] = p;
    return f;
  endfunction

  function automatic logic [3:0] char_bits(input asf_cfg_t c, input logic [1:0] sb);
    return 4'(1 + c.data_bits + (c.parity != PAR_NONE) + sb);
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  always_comb begin
    s_d = s_q;
    f_pop = 1'b0;
    ch_v = 1'b0;
    ch = 8'h00;
    b = 8'h00;
    hit = 1'b0;
    end_m = 1'b0;
    em_v = 1'b0;
    em = '0;
    exp_f = '0;
    s_d.abort = 1'b0;
    s_d.ovr = 1'b0;
    s_d.perr = 1'b0;
    s_d.ferr = 1'b0;
    run = s_q.cfg.en && s_q.cfg_seen;
    div = baud_div(s_q.cfg.baud);
    if (cfg_load) begin
      s_d.cfg = cfg_in;
      s_d.cfg_seen = 1'b1;
    end
    s_d.tick = s_q.pre == 16'(MS_DIV - 1);
    s_d.pre = s_d.tick ? 16'h0000 : s_q.pre + 16'h0001;
    s_d.rxd_prev = rxd;
    if (!s_q.rx_busy) begin
      if (s_q.rxd_prev && !rxd) begin
        s_d.rx_busy = 1'b1;
        s_d.rx_baud = div >> 1;
        s_d.rx_idx = 4'h0;
      end
    end else if (s_q.rx_baud != '0) begin
      s_d.rx_baud = s_q.rx_baud - 19'h00001;
    end else begin
      s_d.rx_sh[s_q.rx_idx] = rxd;
      s_d.rx_baud = div - 19'h00001;
      s_d.rx_idx = s_q.rx_idx + 4'h1;
      if (s_q.rx_idx == 4'h0 && rxd) begin
        s_d.rx_busy = 1'b0;
      end else if (s_q.rx_idx == char_bits(s_q.cfg, 2'h1) - 4'h1) begin
        s_d.rx_busy = 1'b0;
        ch_v = run;
        ch = s_d.rx_sh[8:1] & (8'hff >> (8 - s_q.cfg.data_bits));
        exp_f = char_frame(ch, s_q.cfg);
        s_d.ferr = run && !rxd;
        s_d.perr = run && s_q.cfg.parity != PAR_NONE && s_d.rx_sh[s_q.cfg.data_bits+1] != exp_f[s_q.cfg.data_bits+1];
      end
    end
    if (ch_v && s_q.cfg.hs == HS_XONXOFF && (ch == XON_CHAR || ch == XOFF_CHAR)) begin
      s_d.xoff = ch == XOFF_CHAR;
      ch_v = 1'b0;
    end
    for (int k = 0; k < TERM_N; k++) begin
      if (k < s_q.cfg.term_char_count && s_q.cfg.term_chars[k] == ch) hit = 1'b1;
    end
    if (ch_v) begin
      s_d.msg_act = 1'b1;
      if (!s_q.msg_act) s_d.msg_ms = 16'h0000;
      s_d.gap_ms = 16'h0000;
      s_d.cnt = s_q.cnt + 13'h0001;
      end_m = (s_q.cfg.frame[FT_TERM] && hit) ||
        (s_q.cfg.frame[FT_LEN] && s_q.cfg.pkt_len != '0 && s_d.cnt >= s_q.cfg.pkt_len);
      if (s_q.have_lo) begin
        em_v = 1'b1;
        em.nbytes = 2'h2;
        em.data = s_q.cfg.rx_swap ? {s_q.lo, ch} : {ch, s_q.lo};
        s_d.have_lo = 1'b0;
      end else if (end_m) begin
        em_v = 1'b1;
        em.nbytes = 2'h1;
        em.data = {8'h00, ch};
      end else begin
        s_d.lo = ch;
        s_d.have_lo = 1'b1;
      end
    end else if (s_q.msg_act) begin
      if (s_q.tick) begin
        s_d.msg_ms = sat_inc(s_q.msg_ms);
        s_d.gap_ms = sat_inc(s_q.gap_ms);
      end
      end_m = (s_q.cfg.frame[FT_MSG] && s_q.msg_ms >= s_q.cfg.rx_msg_to) ||
        (s_q.cfg.frame[FT_GAP] && s_q.gap_ms >= s_q.cfg.rx_gap);
      if (end_m) begin
        em_v = 1'b1;
        em.nbytes = {1'b0, s_q.have_lo};
        em.data = {8'h00, s_q.lo};
        s_d.have_lo = 1'b0;
      end
    end
    // frame field zero never sets end_m, so characters only ever stream through
    if (end_m) begin
      em.eom = 1'b1;
      s_d.msg_act = 1'b0;
      s_d.cnt = '0;
      s_d.msg_ms = 16'h0000;
      s_d.gap_ms = 16'h0000;
    end
    if (rx_ready) s_d.out_v = 1'b0;
    // the line cannot be held back, so a new word arriving while the host has not taken the last one is dropped and flagged
    if (em_v) begin
      if (s_q.out_v && !rx_ready) begin
        s_d.ovr = 1'b1;
      end else begin
        s_d.out_v = 1'b1;
        s_d.out = em;
      end
    end
    case (s_q.cfg.hs)
      HS_RTSCTS: gate = cts;
      HS_DTRDSR: gate = dsr;
      HS_XONXOFF: gate = !s_q.xoff;
      default: gate = 1'b1;
    endcase
    if (s_q.tick && (s_q.tx_st & (TX_PRE | TX_RTSON | TX_RTSOFF)) != '0) s_d.tx_ms = sat_inc(s_q.tx_ms);
    if (s_q.tick && (s_q.tx_st & (TX_PRE | TX_RTSON | TX_SEND)) != '0) s_d.tx_to_ms = sat_inc(s_q.tx_to_ms);
    if (s_q.tx_bits != 4'h0) begin
      if (s_q.tx_baud != '0) begin
        s_d.tx_baud = s_q.tx_baud - 19'h00001;
      end else begin
        s_d.tx_sh = {1'b1, s_q.tx_sh[11:1]};
        s_d.tx_bits = s_q.tx_bits - 4'h1;
        s_d.tx_baud = div - 19'h00001;
      end
    end
    case (s_q.tx_st)
      TX_IDLE: begin
        if (run && f_v) begin
          s_d.tx_st = TX_PRE;
          s_d.tx_ms = 16'h0000;
          s_d.tx_to_ms = 16'h0000;
          s_d.tx_end = 1'b0;
          s_d.tx_hi = 1'b0;
          s_d.tx_w = '0;
        end
      end
      TX_PRE: begin
        if (s_q.tx_ms >= s_q.cfg.tx_min) begin
          s_d.tx_st = TX_RTSON;
          s_d.rts = 1'b1;
          s_d.tx_ms = 16'h0000;
        end
      end
      TX_RTSON: begin
        if (s_q.tx_ms >= s_q.cfg.rts_on) s_d.tx_st = TX_SEND;
      end
      TX_SEND: begin
        if (s_q.tx_bits == 4'h0) begin
          if (s_q.tx_end) begin
            s_d.tx_st = TX_RTSOFF;
            s_d.tx_ms = 16'h0000;
          end else if (gate && s_q.tx_hi) begin
            b = s_q.cfg.tx_swap ? s_q.tx_w.data[7:0] : s_q.tx_w.data[15:8];
            s_d.tx_hi = 1'b0;
            s_d.tx_end = s_q.tx_w.last;
          end else if (gate && f_v) begin
            f_pop = 1'b1;
            s_d.tx_w = f_data;
            b = s_q.cfg.tx_swap ? f_data.data[15:8] : f_data.data[7:0];
            s_d.tx_hi = 1'b1;
          end
          if (f_pop || (gate && s_q.tx_hi && !s_q.tx_end)) begin
            s_d.tx_sh = char_frame(b, s_q.cfg);
            s_d.tx_bits = char_bits(s_q.cfg, s_q.cfg.stop_bits);
            s_d.tx_baud = div - 19'h00001;
          end
        end
      end
      TX_DRAIN: begin
        f_pop = f_v;
        if (f_v && f_data.last) begin
          s_d.tx_st = TX_RTSOFF;
          s_d.tx_ms = 16'h0000;
        end
      end
      TX_RTSOFF: begin
        if (s_q.tx_ms >= s_q.cfg.rts_off) begin
          s_d.tx_st = TX_IDLE;
          s_d.rts = 1'b0;
        end
      end
      default: s_d.tx_st = TX_IDLE;
    endcase
    // a zero limit disables the timeout; the rest of the aborted message is discarded
    if ((s_q.tx_st & (TX_PRE | TX_RTSON | TX_SEND)) != '0 && s_q.cfg.tx_to != 16'h0000 &&
        s_q.tx_to_ms >= s_q.cfg.tx_to) begin
      s_d.abort = 1'b1;
      s_d.tx_bits = 4'h0;
      s_d.tx_st = s_q.tx_w.last ? TX_RTSOFF : TX_DRAIN;
      s_d.tx_ms = 16'h0000;
    end
    if (!run) begin
      s_d.tx_st = TX_IDLE;
      s_d.rts = 1'b0;
      s_d.tx_bits = 4'h0;
      s_d.xoff = 1'b0;
      s_d.have_lo = 1'b0;
      s_d.msg_act = 1'b0;
      s_d.cnt = '0;
    end
    s_d.txd = (s_d.tx_bits == 4'h0) || s_d.tx_sh[0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.tx_st <= TX_IDLE;
      s_q.txd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg_rb = s_q.cfg;
  assign rx_data = s_q.out;
  assign rx_valid = s_q.out_v;
  assign tx_abort = s_q.abort;
  assign rx_overrun = s_q.ovr;
  assign rx_perr = s_q.perr;
  assign rx_ferr = s_q.ferr;
  assign txd = s_q.txd;
  assign rts = s_q.rts;
  assign dtr = s_q.cfg.en && s_q.cfg_seen;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_port_off_quiet: assert property (!s_q.cfg.en |=> s_q.tx_st == TX_IDLE && txd && !rts)
    else $error("port active while disabled");
  chk_stream_no_eom: assert property ($rose(rx_valid) && $past(s_q.cfg.frame) == 4'h0 |-> !rx_data.eom)
    else $error("message end seen in stream mode");
  chk_rtson_line_idle: assert property (s_q.tx_st == TX_RTSON |-> rts && txd)
    else $error("data or rts wrong during rts-on delay");
  chk_pre_rts_low: assert property (s_q.tx_st == TX_PRE |-> !rts && txd)
    else $error("rts raised before pre-send delay elapsed");
  chk_idle_rts_low: assert property ($fell(rts) |-> $past(s_q.tx_st) == TX_RTSOFF || !$past(run))
    else $error("rts dropped outside the rts-off phase");
  chk_pkt_len_cap: assert property (s_q.cfg.frame[FT_LEN] && s_q.cfg.pkt_len != '0 && $stable(s_q.cfg.pkt_len)
    && $past(s_q.cnt) < s_q.cfg.pkt_len |-> s_q.cnt < s_q.cfg.pkt_len)
    else $error("byte count passed packet length");
  chk_abort_cause: assert property (tx_abort |-> $past(s_q.cfg.tx_to) != 16'h0000 &&
    $past(s_q.tx_to_ms) >= $past(s_q.cfg.tx_to) ##1 !tx_abort && s_q.tx_bits == 4'h0)
    else $error("abort without timeout");
  chk_cfg_copy: assert property (cfg_load |=> cfg_rb == $past(cfg_in))
    else $error("configuration copy not loaded");
  chk_tick_single: assert property (s_q.tick |=> !s_q.tick)
    else $error("millisecond tick longer than one cycle");

  cov_tx_abort: cover property (tx_abort);
  cov_rx_eom: cover property (rx_valid && rx_data.eom && rx_data.nbytes == 2'h2);
  cov_tx_done: cover property (s_q.tx_st == TX_RTSOFF ##1 s_q.tx_st == TX_IDLE);
endmodule

// ### tb/asf_remote.sv
/*
  remote serial device: sends characters on rxd and decodes what arrives on txd.
  assumes pins sampled on core_clk, a 115200 line and the port's character format on its inputs.
*/
`timescale 1ns/100ps
module asf_remote import asf_pkg::*; (
  input wire logic core_clk, // clock
  input wire logic txd, // line from port
  output logic rxd, // line to port
  output logic cts, // clear to send
  output logic dsr, // set ready
  input wire logic stall, // hold flow control off
  input wire logic [3:0] nbits, // data bits
  input wire asf_par_t par, // parity kind
  input wire logic [1:0] nstop, // stop bits
  output logic got, // pulse: char decoded
  output logic [8:0] got_ch // format ok, char
);
  localparam int BITC = CLK_HZ / 115200;
  logic [7:0] d;
  logic ok;
  // both hardware lines follow one stall so either handshake mode can be starved
  assign cts = !stall;
  assign dsr = !stall;
  function automatic logic pbit(input logic [7:0] c);
    logic x;
    x = ^(c & ((8'h01 << nbits) - 8'h01));
    case (par)
      PAR_ODD: return !x;
      PAR_EVEN: return x;
      PAR_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic skip(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic put(input logic b);
    rxd = b;
    skip(BITC);
  endtask
  task automatic send(input logic [7:0] c);
    @(posedge core_clk);
    #1 put(1'b0);
    for (int i = 0; i < nbits; i++) put(c[i]);
    if (par != PAR_NONE) put(pbit(c));
    for (int i = 0; i < nstop; i++) put(1'b1);
  endtask
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_ch = 9'h000;
    forever begin
      @(posedge core_clk);
      #1 got = 1'b0;
      if (txd === 1'b0) begin
        d = 8'h00;
        skip(BITC / 2 - 1);
        for (int i = 0; i < nbits; i++) begin
          skip(BITC - 1);
          d[i] = txd;
        end
        ok = 1'b1;
        if (par != PAR_NONE) begin
          skip(BITC - 1);
          ok = (txd === pbit(d));
        end
        for (int i = 0; i < nstop; i++) begin
          skip(BITC - 1);
          ok = ok & (txd === 1'b1);
        end
        got_ch = {ok, d};
        got = 1'b1;
      end
    end
  end
endmodule

// ### tb/tb_top.sv
/*
  self-checking bench of the serial port: receive framing, transmit sequencing, fifo fill.
  assumes asf_pkg and the remote model; drivers queue expectations, a monitor pops them.
*/
`timescale 1ns/100ps
module tb_top import asf_pkg::*; ;
  localparam int MSD = 20;
  logic core_clk = 1'b0, rst = 1'b1, cfg_load = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0, stall = 1'b0;
  logic tx_ready, rx_valid, tx_abort, rx_overrun, rx_perr, rx_ferr, txd, rts, dtr, rxd, cts, dsr, got;
  logic [8:0] got_ch;
  logic [31:0] seed = 32'h9130;
  asf_cfg_t cfg_in, cfg_rb;
  asf_txw_t tx_data;
  asf_rxw_t rx_data, sw, ew;
  asf_rxw_t rxq[$];
  logic [8:0] txq[$];
  int n_errors = 0, compares = 0;
  int n_perr = 0, n_bad = 0;
  always #10 core_clk = !core_clk;
  asf_port #(.MS_DIV(MSD)) u_dut (.core_clk(core_clk), .rst(rst), .cfg_in(cfg_in),
    .cfg_load(cfg_load), .cfg_rb(cfg_rb), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_abort(tx_abort),
    .rx_overrun(rx_overrun), .rx_perr(rx_perr), .rx_ferr(rx_ferr), .txd(txd), .rts(rts), .dtr(dtr),
    .rxd(rxd), .cts(cts), .dsr(dsr));
  asf_remote u_remote (.core_clk(core_clk), .txd(txd), .rxd(rxd), .cts(cts), .dsr(dsr), .stall(stall),
    .nbits(cfg_in.data_bits), .par(cfg_in.parity), .nstop(cfg_in.stop_bits), .got(got), .got_ch(got_ch));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic asf_rxw_t rw(input logic [15:0] d, input logic [1:0] nb, input logic e);
    return '{data: d, nbytes: nb, eom: e};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return rxq.size() == 0 && txq.size() == 0;
      1: return txd === 1'b0;
      2: return rts === 1'b0;
      default: return tx_abort === 1'b1;
    endcase
  endfunction
  task automatic wait_for(input int k, input int lim, output int n);
    for (n = 0; n < lim && !cond(k); n++) begin
      @(posedge core_clk);
      #1;
    end
    if (!cond(k)) begin
      n_errors++;
      finish_test();
    end
  endtask
  task automatic load(input asf_cfg_t c);
    @(posedge core_clk);
    #1 cfg_in = c;
    cfg_load = 1'b1;
    @(posedge core_clk);
    #1 cfg_load = 1'b0;
    @(posedge core_clk);
    #1 check("cfg_rb", 32'(cfg_rb === c), 32'h1);
    check("dtr", 32'(dtr), 32'(c.en));
  endtask
  task automatic push(input logic [15:0] w, input logic last, input int lim, output logic ok);
    @(posedge core_clk);
    #1 tx_data = {last, w};
    tx_valid = 1'b1;
    for (int n = 0; n < lim && tx_ready !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    ok = (tx_ready === 1'b1);
    @(posedge core_clk);
    #1 tx_valid = 1'b0;
  endtask
  // the random stream advances on the edge so that readers a step later see a settled value
  always @(posedge core_clk) begin
    seed = lfsr(seed);
    #1 rx_ready = seed[0] | seed[3];
  end
  always @(posedge core_clk) begin
    n_perr += int'(rx_perr === 1'b1);
    n_bad += int'(rx_ferr === 1'b1 || rx_overrun === 1'b1);
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (rxq.size() == 0) check("rx_extra", 32'h1, 32'h0);
      else begin
        ew = rxq.pop_front();
        sw = rx_data;
        if (ew.nbytes == 2'd1) sw.data[15:8] = 8'h00;
        check("rx_word", 32'(sw), 32'(ew));
      end
    end
    if (got === 1'b1) begin
      if (txq.size() == 0) check("tx_extra", 32'h1, 32'h0);
      else check("tx_char", 32'(got_ch), 32'(txq.pop_front()));
    end
  end
  initial begin
    repeat (95000) @(posedge core_clk);
    n_errors++;
    finish_test();
  end
  initial begin
    asf_cfg_t c;
    logic [15:0] w0, w1;
    logic ok;
    int n, k;
    cfg_in = '0;
    tx_data = '0;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    check("rst_out", 32'({txd, rts, dtr, rx_valid, tx_ready, cfg_rb === '0}), 32'h23);
    c = '0;
    c.baud = 16'd1150;
    c.data_bits = 4'd8;
    c.stop_bits = 2'd1;
    load(c);
    u_remote.send(8'h41);
    // a disabled port must stay silent; a short idle window exposes any late word
    repeat (300) @(posedge core_clk);
    c.en = 1'b1;
    load(c);
    w0 = seed[15:0];
    rxq.push_back(rw(w0, 2'd2, 1'b0));
    u_remote.send(w0[7:0]);
    u_remote.send(w0[15:8]);
    wait_for(0, 3000, n);
    c.frame = 4'h1;
    c.term_char_count = 4'd2;
    c.term_chars[0] = 8'h0d;
    c.term_chars[1] = 8'h0a;
    c.term_chars[2] = 8'h21;
    load(c);
    rxq.push_back(rw(16'h2141, 2'd2, 1'b0));
    rxq.push_back(rw(16'h000a, 2'd1, 1'b1));
    u_remote.send(8'h41);
    u_remote.send(8'h21);
    u_remote.send(8'h0a);
    wait_for(0, 3000, n);
    c.frame = 4'h8;
    c.pkt_len = 13'd2;
    c.rx_swap = 1'b1;
    c.baud = 16'd115;
    load(c);
    rxq.push_back(rw(16'h3132, 2'd2, 1'b1));
    u_remote.send(8'h31);
    u_remote.send(8'h32);
    wait_for(0, 3000, n);
    c.frame = 4'h4;
    c.rx_gap = 16'd2;
    c.rx_swap = 1'b0;
    c.parity = PAR_ODD;
    load(c);
    // the remote follows cfg_in, so this one character goes out with the wrong parity
    cfg_in.parity = PAR_EVEN;
    w1 = seed[31:16];
    rxq.push_back(rw({8'h00, w1[7:0]}, 2'd1, 1'b1));
    u_remote.send(w1[7:0]);
    wait_for(0, 3000, n);
    c.parity = PAR_NONE;
    c.tx_min = 16'd20;
    c.rts_on = 16'd20;
    c.rts_off = 16'd20;
    load(c);
    w0 = seed[15:0];
    w1 = seed[31:16];
    txq.push_back({1'b1, w0[7:0]});
    txq.push_back({1'b1, w0[15:8]});
    txq.push_back({1'b1, w1[7:0]});
    txq.push_back({1'b1, w1[15:8]});
    push(w0, 1'b0, 10, ok);
    push(w1, 1'b1, 10, ok);
    wait_for(1, 2000, n);
    check("rts_lead", 32'(rts === 1'b1 && n >= (c.tx_min + c.rts_on - 2) * MSD), 32'h1);
    wait_for(0, 30000, n);
    wait_for(2, 2000, n);
    check("rts_tail", 32'(n >= (c.rts_off - 1) * MSD && n <= (c.rts_off + 1) * MSD + 434), 32'h1);
    c.data_bits = 4'd7;
    c.parity = PAR_EVEN;
    c.stop_bits = 2'd2;
    c.tx_swap = 1'b1;
    c.tx_min = 16'd0;
    c.rts_on = 16'd0;
    c.rts_off = 16'd0;
    load(c);
    w0 = seed[15:0];
    txq.push_back({2'b10, w0[14:8]});
    txq.push_back({2'b10, w0[6:0]});
    push(w0, 1'b1, 10, ok);
    wait_for(0, 20000, n);
    // xoff from the far side must hold the word back until xon; short characters keep the run brief
    c.data_bits = 4'd5;
    c.parity = PAR_MARK;
    c.stop_bits = 2'd1;
    c.tx_swap = 1'b0;
    c.hs = HS_XONXOFF;
    c.frame = 4'h2;
    c.rx_msg_to = 16'd3;
    load(c);
    u_remote.send(XOFF_CHAR);
    w0 = seed[15:0];
    txq.push_back({4'b1000, w0[4:0]});
    txq.push_back({4'b1000, w0[12:8]});
    push(w0, 1'b1, 10, ok);
    rxq.push_back(rw(16'h0005, 2'd1, 1'b1));
    u_remote.send(8'h05);
    repeat (100) @(posedge core_clk);
    #1 check("xoff_hold", 32'(rxq.size() == 0 && txq.size() == 2 && txd === 1'b1), 32'h1);
    u_remote.send(XON_CHAR);
    wait_for(0, 10000, n);
    c.hs = HS_RTSCTS;
    c.tx_to = 16'd20;
    c.tx_swap = 1'b0;
    stall = 1'b1;
    load(c);
    k = 0;
    ok = 1'b1;
    for (n = 0; n < 40 && ok; n++) begin
      push(seed[15:0], 1'b0, 2, ok);
      k += int'(ok);
    end
    check("fill", 32'(k >= FIFO_DEPTH && k <= FIFO_DEPTH + 1 && tx_ready === 1'b0), 32'h1);
    wait_for(3, 1000, n);
    push(16'h0000, 1'b1, 600, ok);
    check("tail_room", 32'(ok), 32'h1);
    wait_for(2, 2000, n);
    repeat (4) @(posedge core_clk);
    #1 check("drained", 32'(tx_ready), 32'h1);
    check("rx_perr", 32'(n_perr), 32'h1);
    check("rx_ferr_ovr", 32'(n_bad), 32'h0);
    stall = 1'b0;
    finish_test();
  end
endmodule
